// [gph_pkg.sv]
// package for the eight-bit general-purpose port with pin overrides
package gph_pkg;
	localparam int unsigned GPH_WIDTH     = 8;
	localparam int unsigned GPH_ADDR_W    = 2;
	// word offsets on the register bus
	localparam logic [1:0]  GPH_OFF_PIN   = 2'h0;
	localparam logic [1:0]  GPH_OFF_LATCH = 2'h1;
	localparam logic [1:0]  GPH_OFF_DIR   = 2'h2;
	localparam logic [1:0]  GPH_OFF_CFG   = 2'h3;
	// configuration register fields
	localparam int unsigned GPH_CFG_PCFG_LSB = 0;
	localparam int unsigned GPH_CFG_REMAP    = 4;
	localparam int unsigned GPH_CFG_SDTRI    = 5;
	localparam logic [7:0]  GPH_LATCH_RST = 8'h00;
	localparam logic [7:0]  GPH_DIR_RST   = 8'hff;
	// converter field reset: every shared pin analog after reset
	localparam logic [3:0]  GPH_PCFG_RST  = 4'h0;
	// field values below this make pins 4..7 analog (channels 12..15)
	localparam logic [3:0]  GPH_PCFG_DIG_MIN = 4'h4;
	localparam logic [7:0]  GPH_CFG_RST   = 8'h00;
	localparam logic [31:0] GPH_UNMAPPED  = 32'h0000_0000;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} gph_drive_s;

	typedef struct packed {
		logic       unit_one_channel_b;
		logic       unit_one_channel_c;
		logic       unit_three_channel_b;
		logic       unit_three_channel_c;
		logic       unit_one_shutdown;
		logic       unit_three_shutdown;
	} gph_pwm_s;

	typedef enum logic [1:0] {
		GPH_IDLE = 2'b01,
		GPH_RESP = 2'b10
	} gph_bus_e;
endpackage : gph_pkg

// [gph_sync.sv]
// two-flop synchroniser for the pin levels
`timescale 1ns/1ps
`default_nettype none
module gph_sync #(
	parameter int unsigned WIDTH = 8
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// data
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule // gph_sync
`default_nettype wire

// [gph_port.sv]
// eight-bit general-purpose port with memory and pwm overrides and analog selection
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module gph_port
	import gph_pkg::*;
#(
	parameter int unsigned PIN_COUNT = 100,
	parameter int unsigned WIDTH     = GPH_WIDTH
) (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// avalon-mm slave
	input  wire logic [GPH_ADDR_W-1:0] avs_address,
	input  wire logic                  avs_read,
	input  wire logic                  avs_write,
	input  wire logic [31:0]           avs_writedata,
	input  wire logic [3:0]            avs_byteenable,
	output logic      [31:0]           avs_readdata,
	output logic                       avs_waitrequest,
	// memory interface overrides
	input  wire logic                  mem_enable,
	input  wire logic [3:0]            mem_address_hi,
	// pwm overrides
	input  wire gph_pwm_s              pwm,
	// analog selection seen by the converter
	output logic      [3:0]            analog_select,
	// pins
	input  wire logic [WIDTH-1:0]      pin_in,
	output logic      [WIDTH-1:0]      pin_out,
	output logic      [WIDTH-1:0]      pin_oe
);
	localparam bit PRESENT = (PIN_COUNT >= 80);

	logic [WIDTH-1:0] output_latch_register;
	logic [WIDTH-1:0] direction_register;
	logic [7:0]       cfg;
	logic [WIDTH-1:0] pin_sync;
	logic [31:0]      next_readdata;
	gph_bus_e         state;

	gph_sync #(
		.WIDTH(WIDTH)
	) u_sync (
		.clk  (clk),
		.rst_n(rst_n),
		.d    (pin_in),
		.q    (pin_sync)
	);

	// bus decode: writes take effect when waitrequest is low (response cycle)
	wire       acc       = avs_read | avs_write;
	wire       take      = (state == GPH_RESP);
	wire       wr        = take & avs_write & avs_byteenable[0];
	wire       wr_latch  = wr & ((avs_address == GPH_OFF_LATCH) |
		(avs_address == GPH_OFF_PIN));
	wire       wr_dir    = wr & (avs_address == GPH_OFF_DIR);
	wire       wr_cfg    = wr & (avs_address == GPH_OFF_CFG);

	wire [3:0] pcfg      = cfg[GPH_CFG_PCFG_LSB +: 4];
	wire       remap_clr = ~cfg[GPH_CFG_REMAP];
	wire       sd_tri    = cfg[GPH_CFG_SDTRI];
	// lower field values select analog on the shared pins
	wire       analog_on = (pcfg < GPH_PCFG_DIG_MIN);

	assign avs_waitrequest = acc & (state == GPH_IDLE);
	assign analog_select   = PRESENT ? {4{analog_on}} : 4'h0;

	always_comb begin
		next_readdata = GPH_UNMAPPED;
		case (avs_address)
			GPH_OFF_PIN:   next_readdata[WIDTH-1:0] = pin_sync;
			GPH_OFF_LATCH: next_readdata[WIDTH-1:0] =
				output_latch_register;
			GPH_OFF_DIR:   next_readdata[WIDTH-1:0] = direction_register;
			GPH_OFF_CFG:   next_readdata[7:0] = cfg;
			default:       next_readdata = GPH_UNMAPPED;
		endcase
	end

	// one wait cycle per access keeps readdata registered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= GPH_IDLE;
		end else begin
			case (state)
				GPH_IDLE: if (acc) state <= GPH_RESP;
				GPH_RESP: state <= GPH_IDLE;
				default:  state <= GPH_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= GPH_UNMAPPED;
		end else if (avs_read && state == GPH_IDLE) begin
			avs_readdata <= PRESENT ? next_readdata : GPH_UNMAPPED;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			output_latch_register <= GPH_LATCH_RST;
			direction_register    <= GPH_DIR_RST;
			cfg                   <= GPH_CFG_RST;
		end else begin
			if (wr_latch) output_latch_register <= avs_writedata[WIDTH-1:0];
			if (wr_dir)   direction_register    <= avs_writedata[WIDTH-1:0];
			if (wr_cfg)   cfg                   <= avs_writedata[7:0];
		end
	end

	// per-pin output mux; priority memory > pwm > latch
	logic [WIDTH-1:0] pwm_val;
	logic [WIDTH-1:0] pwm_sd;
	assign pwm_val = {pwm.unit_one_channel_b, pwm.unit_one_channel_c,
		pwm.unit_three_channel_b, pwm.unit_three_channel_c, 4'h0};
	assign pwm_sd  = {{2{pwm.unit_one_shutdown}},
		{2{pwm.unit_three_shutdown}}, 4'h0};

	gph_drive_s drv;
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_pin
			wire lo     = (i < 4);
			wire mem_ov = lo & mem_enable;
			// pwm wins only while software has made the pin an output
			wire pwm_ov = ~lo & remap_clr & ~direction_register[i];
			wire mem_d  = lo ? mem_address_hi[i % 4] : 1'b0;
			// analog selection leaves the output path alone
			assign drv.out[i] = mem_ov ? mem_d :
				pwm_ov ? pwm_val[i] : output_latch_register[i];
			assign drv.oe[i]  = mem_ov ? 1'b1 :
				(pwm_ov & sd_tri & pwm_sd[i]) ? 1'b0 :
				~direction_register[i];
		end
	endgenerate

	assign pin_out = PRESENT ? drv.out : '0;
	assign pin_oe  = PRESENT ? drv.oe : '0;

	check_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
		(PRESENT && !mem_enable && direction_register[0]) |-> !pin_oe[0])
		else $error("pin 0 driven while input");
	latch_drv_a: assert property (@(posedge clk) disable iff (!rst_n)
		(PRESENT && !mem_enable && !direction_register[1]) |->
		pin_oe[1] && pin_out[1] == output_latch_register[1])
		else $error("pin 1 not driving latch");
	mem_addr_a: assert property (@(posedge clk) disable iff (!rst_n)
		(PRESENT && mem_enable) |->
		pin_oe[3:0] == 4'hf && pin_out[3:0] == mem_address_hi)
		else $error("address not on low pins");
	latch_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
		(avs_read && avs_address == GPH_OFF_LATCH && !avs_waitrequest
		&& PRESENT) |->
		avs_readdata[WIDTH-1:0] == output_latch_register)
		else $error("latch readback wrong");
	pin_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
		(avs_write && !avs_waitrequest && avs_byteenable[0] &&
		avs_address == GPH_OFF_PIN) |=>
		output_latch_register == $past(avs_writedata[WIDTH-1:0]))
		else $error("pin write missed latch");
	pwm_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
		(PRESENT && remap_clr && !direction_register[7] && !sd_tri) |->
		pin_out[7] == pwm.unit_one_channel_b && pin_oe[7])
		else $error("pwm not on pin 7");
	pwm_dir_a: assert property (@(posedge clk) disable iff (!rst_n)
		(PRESENT && direction_register[4]) |-> !pin_oe[4])
		else $error("pwm drove input pin");
	pwm_tri_a: assert property (@(posedge clk) disable iff (!rst_n)
		(PRESENT && remap_clr && sd_tri && pwm.unit_three_shutdown) |->
		pin_oe[5:4] == 2'h0)
		else $error("shutdown pins still driven");
	wait_one_a: assert property (@(posedge clk) disable iff (!rst_n)
		(acc && avs_waitrequest) |=> !avs_waitrequest)
		else $error("wait longer than one cycle");
	// shared pins fall back to analog whenever the field holds its reset code
	ana_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
		(PRESENT && pcfg == GPH_PCFG_RST) |-> analog_select == 4'hf)
		else $error("shared pins not analog");
	// analog selection must not cut the digital driver of a shared pin
	ana_drive_a: assert property (@(posedge clk) disable iff (!rst_n)
		(PRESENT && analog_on && !remap_clr && !direction_register[5]) |->
		pin_oe[5] && pin_out[5] == output_latch_register[5])
		else $error("analog pin lost driver");
	// with the remap bit set the latch keeps the upper pins
	remap_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		(PRESENT && !remap_clr && !direction_register[6]) |->
		pin_out[6] == output_latch_register[6])
		else $error("pwm on pin without remap");
	// a write with lane 0 off leaves the latch alone
	lane_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
		(avs_write && !avs_waitrequest && !avs_byteenable[0] &&
		avs_address == GPH_OFF_LATCH) |=> $stable(output_latch_register))
		else $error("masked write changed latch");
	dir_rd_a: assert property (@(posedge clk) disable iff (!rst_n)
		(avs_read && avs_address == GPH_OFF_DIR && !avs_waitrequest
		&& PRESENT) |->
		avs_readdata[WIDTH-1:0] == direction_register)
		else $error("direction readback wrong");

	cov_mem_c:   cover property (@(posedge clk) disable iff (!rst_n)
		mem_enable && pin_oe[0]);
	cov_pwm_c:   cover property (@(posedge clk) disable iff (!rst_n)
		remap_clr && pin_oe[6]);
	cov_write_c: cover property (@(posedge clk) disable iff (!rst_n)
		wr_dir);
	cov_tri_c:   cover property (@(posedge clk) disable iff (!rst_n)
		remap_clr && sd_tri && pwm.unit_one_shutdown &&
		!direction_register[6]);
endmodule // gph_port
`default_nettype wire

// [gph_pads.sv]
// pad model: resolves each port pin from the port driver and the board
`timescale 1ns/1ps
`default_nettype none
module gph_pads (
	// port side
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	// board side
	input  wire logic [7:0] ext_drive,
	output logic      [7:0] pin_in
);
	// the port driver overpowers the board's weak source, so the
	// board value only shows where the port has let go
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drive);
endmodule // gph_pads
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the eight-bit port with overrides
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import gph_pkg::*;
	logic        clk = 0, rst_n = 0, rd = 0, wr = 0, me = 0;
	logic        wq;
	logic [1:0]  adr = 0;
	logic [3:0]  be = 0, ma = 0, asel;
	logic [31:0] wd = 0, rdat;
	logic [7:0]  ext = 0, po, poe, pi, q, lat, dir, cfg;
	logic [15:0] x;
	gph_pwm_s    pw = '0;
	int          errors = 0, checked = 0, cyc = 0, seed = 59801;

	always #20 clk = ~clk;

	gph_port dut (.clk(clk), .rst_n(rst_n), .avs_address(adr),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd),
		.avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq),
		.mem_enable(me), .mem_address_hi(ma), .pwm(pw),
		.analog_select(asel), .pin_in(pi), .pin_out(po), .pin_oe(poe));
	gph_pads pads (.pin_out(po), .pin_oe(poe), .ext_drive(ext),
		.pin_in(pi));

	task automatic test_done;
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] e, g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask

	// one avalon transfer; waitrequest is sampled where it stands
	task automatic bus(input logic w, input logic [1:0] a,
		input logic [7:0] d, input logic [3:0] b);
		logic busy;
		@(posedge clk);
		adr <= a;
		wr <= w;
		rd <= !w;
		wd <= {24'h0, d};
		be <= b;
		busy = 1;
		while (busy) begin
			@(negedge clk);
			busy = wq;
			@(posedge clk);
		end
		// readdata stands at the edge where waitrequest is seen low
		q = rdat[7:0];
		rd <= 0;
		wr <= 0;
	endtask

	// expected {oe, out & oe} from the registers and override inputs
	function automatic logic [15:0] exp_pins();
		logic [7:0] o, e;
		o = lat;
		e = ~dir;
		if (!cfg[GPH_CFG_REMAP]) begin
			// pwm fields run msb first: pins 7..4
			o[7:4] = pw[5:2];
			if (cfg[GPH_CFG_SDTRI] && pw.unit_three_shutdown)
				e[5:4] = 2'h0;
			if (cfg[GPH_CFG_SDTRI] && pw.unit_one_shutdown)
				e[7:6] = 2'h0;
		end
		if (me) begin
			o[3:0] = ma;
			e[3:0] = 4'hf;
		end
		return {e, o & e};
	endfunction

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			test_done();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		bus(0, GPH_OFF_DIR, 8'h00, 4'hf);
		chk("dir_rst", 16'h00ff, {8'h0, q});
		bus(0, GPH_OFF_LATCH, 8'h00, 4'hf);
		chk("lat_rst", 16'h0000, {8'h0, q});
		chk("oe_rst", 16'h0000, {8'h0, poe});
		chk("ana_rst", 16'h000f, {12'h0, asel});
		for (int i = 0; i < 24; i++) begin
			lat = 8'($random(seed));
			dir = 8'($random(seed));
			cfg = 8'($random(seed)) & 8'h3f;
			if (i < 2)
				cfg = 8'h0f;
			@(posedge clk);
			ext <= 8'($random(seed));
			me <= i[1];
			ma <= 4'($random(seed));
			pw <= 6'($random(seed));
			bus(1, i[0] ? GPH_OFF_PIN : GPH_OFF_LATCH, lat, 4'hf);
			// lane 0 off: this write must be dropped
			bus(1, GPH_OFF_LATCH, ~lat, 4'h0);
			bus(1, GPH_OFF_DIR, dir, 4'hf);
			bus(1, GPH_OFF_CFG, cfg, 4'hf);
			repeat (4) @(negedge clk);
			chk("pins", exp_pins(), {poe, po & poe});
			if (cfg[3:0] < GPH_PCFG_DIG_MIN || cfg[3:0] == 4'hf)
				chk("analog", {12'h0, (cfg[3:0] < GPH_PCFG_DIG_MIN)
					? 4'hf : 4'h0}, {12'h0, asel});
			bus(0, GPH_OFF_LATCH, 8'h00, 4'hf);
			chk("latch", {8'h0, lat}, {8'h0, q});
			bus(0, GPH_OFF_DIR, 8'h00, 4'hf);
			chk("dir", {8'h0, dir}, {8'h0, q});
			x = exp_pins();
			bus(0, GPH_OFF_PIN, 8'h00, 4'hf);
			chk("level", {8'h0, x[7:0] | (~x[15:8] & ext)}, {8'h0, q});
		end
		test_done();
	end
endmodule // tb_top
`default_nettype wire
